// ==== logic/uirq_consts.svh ====
// Offsets, field positions, reset values and sizes for the UART interrupt slice
`ifndef UIRQ_CONSTS_SVH
`define UIRQ_CONSTS_SVH

`define UIRQ_ADDR_W 8
`define UIRQ_OFS_LEVEL 8'h34
`define UIRQ_OFS_MASK 8'h38
`define UIRQ_OFS_RAW 8'h3C
`define UIRQ_OFS_MASKED 8'h40
`define UIRQ_OFS_CLEAR 8'h44
`define UIRQ_TX_LVL_LSB 0
`define UIRQ_RX_LVL_LSB 3
`define UIRQ_LVL_RESET 3'h2
`define UIRQ_SRC_MASK 32'h00001FF2
`define UIRQ_BIT_CTS 1
`define UIRQ_BIT_RX 4
`define UIRQ_BIT_TX 5
`define UIRQ_BIT_RXTO 6
`define UIRQ_BIT_FE 7
`define UIRQ_BIT_PE 8
`define UIRQ_BIT_BE 9
`define UIRQ_BIT_OE 10
`define UIRQ_BIT_XOFF 11
`define UIRQ_BIT_TXFE 12
`define UIRQ_FIFO_DEPTH 64

`endif

// ==== logic/uirq_pkg.sv ====
// Types shared by the UART interrupt slice
package uirq_pkg;
	typedef logic [12:0] uirq_src_t;
	typedef logic [2:0] uirq_lvl_t;
endpackage

// ==== logic/uirq_level_cmp.sv ====
// Trigger-level comparator: FIFO count against a selected fraction of depth
`timescale 1ns/1ps
`default_nettype none
`include "uirq_consts.svh"
module uirq_level_cmp
	import uirq_pkg::*;
#(
	parameter int DEPTH = `UIRQ_FIFO_DEPTH,
	parameter int CW = 7
) (
	input wire uirq_lvl_t sel,
	input wire logic [CW-1:0] count,
	output logic hit
);
	// Threshold as count of entries; codes 011b..101b taken as sequential
	function automatic logic [CW-1:0] thresh(input uirq_lvl_t s);
		int t;
		case (s)
			3'h0: t = DEPTH / 64;
			3'h1: t = DEPTH / 16;
			3'h2: t = DEPTH / 8;
			3'h3: t = DEPTH / 4;
			3'h4: t = DEPTH / 2;
			3'h5: t = (DEPTH * 3) / 4;
			3'h6: t = (DEPTH * 3) / 4;
			default: t = (DEPTH * 3) / 4;
		endcase
		if (t < 1) begin
			t = 1;
		end
		return t[CW-1:0];
	endfunction

	// Level met when count reaches the selected fraction
	always_comb begin
		hit = (count >= thresh(sel));
	end
endmodule
`default_nettype wire

// ==== logic/uirq_top.sv ====
// UART interrupt slice: trigger levels, enable mask, raw and masked pending status
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "uirq_consts.svh"
module uirq_top
	import uirq_pkg::*;
#(
	parameter int DEPTH = `UIRQ_FIFO_DEPTH,
	parameter int CW = 7
) (
	input wire logic SYS_CLK,
	input wire logic RESET,
	input wire logic [`UIRQ_ADDR_W-1:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR_STB,
	input wire logic RD_STB,
	output logic [31:0] RDATA,
	input wire logic [CW-1:0] TX_FIFO_FREE,
	input wire logic [CW-1:0] RX_FIFO_FILL,
	input wire logic CTS_CHANGE_EV,
	input wire logic RX_TIMEOUT_EV,
	input wire logic FRAMING_ERR_EV,
	input wire logic PARITY_ERR_EV,
	input wire logic BREAK_ERR_EV,
	input wire logic OVERRUN_ERR_EV,
	input wire logic FLOW_STOP_EV,
	input wire logic TX_EMPTY_EV,
	output logic IRQ
);
	uirq_lvl_t tx_trigger_level_q, tx_trigger_level_d;
	uirq_lvl_t rx_trigger_level_q, rx_trigger_level_d;
	uirq_src_t mask_q, mask_d;
	uirq_src_t raw_q, raw_d;
	logic [31:0] rdata_q, rdata_d;
	logic irq_q, irq_d;
	logic tx_hit, rx_hit, tx_hit_q, rx_hit_q;
	uirq_src_t set_v, clr_v, masked_pending_view;

	// Widen a 13-bit source vector into a bus word, upper bits zero
	function automatic logic [31:0] widen(input uirq_src_t v);
		return {19'h0, v} & `UIRQ_SRC_MASK;
	endfunction

	// Address match helper for the write and clear decode; the read mux decodes ADDR itself
	function automatic logic hit_at(input logic [`UIRQ_ADDR_W-1:0] a,
			input logic [`UIRQ_ADDR_W-1:0] ofs);
		return a == ofs;
	endfunction

	// Transmit threshold on free space
	uirq_level_cmp #(
		.DEPTH(DEPTH),
		.CW(CW)
	) u_tx_cmp (
		.sel(tx_trigger_level_q),
		.count(TX_FIFO_FREE),
		.hit(tx_hit)
	);

	// Receive threshold on fill; code 110b is three quarters
	uirq_level_cmp #(
		.DEPTH(DEPTH),
		.CW(CW)
	) u_rx_cmp (
		.sel(rx_trigger_level_q),
		.count(RX_FIFO_FILL),
		.hit(rx_hit)
	);

	// Masked view is combinational so it tracks raw and mask in step
	assign masked_pending_view = raw_q & mask_q;

	// Configuration register writes
	always_comb begin
		tx_trigger_level_d = tx_trigger_level_q;
		rx_trigger_level_d = rx_trigger_level_q;
		mask_d = mask_q;
		if (WR_STB && hit_at(ADDR, `UIRQ_OFS_LEVEL)) begin
			tx_trigger_level_d = WDATA[`UIRQ_TX_LVL_LSB +: 3];
			rx_trigger_level_d = WDATA[`UIRQ_RX_LVL_LSB +: 3];
		end
		if (WR_STB && hit_at(ADDR, `UIRQ_OFS_MASK)) begin
			mask_d = WDATA[12:0] & uirq_src_t'(`UIRQ_SRC_MASK);
		end
	end

	// Event sets; level sources set on rising crossing of their threshold
	always_comb begin
		set_v = '0;
		set_v[`UIRQ_BIT_CTS] = CTS_CHANGE_EV;
		set_v[`UIRQ_BIT_RX] = rx_hit & ~rx_hit_q;
		set_v[`UIRQ_BIT_TX] = tx_hit & ~tx_hit_q;
		set_v[`UIRQ_BIT_RXTO] = RX_TIMEOUT_EV;
		set_v[`UIRQ_BIT_FE] = FRAMING_ERR_EV;
		set_v[`UIRQ_BIT_PE] = PARITY_ERR_EV;
		set_v[`UIRQ_BIT_BE] = BREAK_ERR_EV;
		set_v[`UIRQ_BIT_OE] = OVERRUN_ERR_EV;
		set_v[`UIRQ_BIT_XOFF] = FLOW_STOP_EV;
		set_v[`UIRQ_BIT_TXFE] = TX_EMPTY_EV;
		clr_v = '0;
		if (WR_STB && hit_at(ADDR, `UIRQ_OFS_CLEAR)) begin
			clr_v = WDATA[12:0];
		end
	end

	// Set beats clear so an event in the clear cycle is not lost
	always_comb begin
		raw_d = ((raw_q & ~clr_v) | set_v) & uirq_src_t'(`UIRQ_SRC_MASK);
	end

	// Read mux; unmapped and write-only offsets read zero
	always_comb begin
		rdata_d = 32'h0;
		if (RD_STB) begin
			case (ADDR)
				`UIRQ_OFS_LEVEL: rdata_d = {26'h0, rx_trigger_level_q, tx_trigger_level_q};
				`UIRQ_OFS_MASK: rdata_d = widen(mask_q);
				`UIRQ_OFS_RAW: rdata_d = widen(raw_q);
				`UIRQ_OFS_MASKED: rdata_d = widen(masked_pending_view);
				default: rdata_d = 32'h0;
			endcase
		end
	end

	// Interrupt from next state so IRQ tracks raw_q and mask_q in the same cycle
	always_comb begin
		irq_d = |((raw_d & mask_d));
	end

	// State registers, synchronous reset
	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			tx_trigger_level_q <= `UIRQ_LVL_RESET;
			rx_trigger_level_q <= `UIRQ_LVL_RESET;
			mask_q <= '0;
			raw_q <= '0;
			rdata_q <= 32'h0;
			irq_q <= 1'b0;
			tx_hit_q <= 1'b0;
			rx_hit_q <= 1'b0;
		end else begin
			tx_trigger_level_q <= tx_trigger_level_d;
			rx_trigger_level_q <= rx_trigger_level_d;
			mask_q <= mask_d;
			raw_q <= raw_d;
			rdata_q <= rdata_d;
			irq_q <= irq_d;
			tx_hit_q <= tx_hit;
			rx_hit_q <= rx_hit;
		end
	end

	assign RDATA = rdata_q;
	assign IRQ = irq_q;

	// Mask write lands on the next edge with the reserved bits cleared
	a_mask_write: assert property (@(posedge SYS_CLK) disable iff (RESET)
		(WR_STB && ADDR == `UIRQ_OFS_MASK) |=> mask_q == ($past(WDATA[12:0]) & 13'h1FF2))
		else $error("mask write not stored");

	// Mask reads return stored enables, reserved zero
	a_mask_read: assert property (@(posedge SYS_CLK) disable iff (RESET)
		(RD_STB && ADDR == `UIRQ_OFS_MASK) |=> RDATA == {19'h0, $past(mask_q) & 13'h1FF2})
		else $error("mask readback wrong");

	// An event sets its raw bit even during a clear
	a_event_sets: assert property (@(posedge SYS_CLK) disable iff (RESET)
		OVERRUN_ERR_EV |=> raw_q[`UIRQ_BIT_OE])
		else $error("overrun event lost");

	// A clear with no new event drops the bit
	a_clear_drops: assert property (@(posedge SYS_CLK) disable iff (RESET)
		(WR_STB && ADDR == `UIRQ_OFS_CLEAR && WDATA[`UIRQ_BIT_FE] && !FRAMING_ERR_EV)
		|=> !raw_q[`UIRQ_BIT_FE])
		else $error("framing clear ignored");

	// Writing zero to clear leaves a pending bit standing
	a_clear_zero: assert property (@(posedge SYS_CLK) disable iff (RESET)
		(WR_STB && ADDR == `UIRQ_OFS_CLEAR && !WDATA[`UIRQ_BIT_PE] && raw_q[`UIRQ_BIT_PE])
		|=> raw_q[`UIRQ_BIT_PE])
		else $error("parity bit cleared by zero");

	// Interrupt equals any masked pending bit
	a_irq_level: assert property (@(posedge SYS_CLK) disable iff (RESET)
		IRQ == |(raw_q & mask_q))
		else $error("irq does not follow masked status");

	// Masked view read matches raw and mask of the read cycle
	a_masked_read: assert property (@(posedge SYS_CLK) disable iff (RESET)
		(RD_STB && ADDR == `UIRQ_OFS_MASKED)
		|=> RDATA == {19'h0, $past(raw_q) & $past(mask_q)})
		else $error("masked view wrong");

	// Receive crossing of threshold raises its raw bit
	a_rx_level: assert property (@(posedge SYS_CLK) disable iff (RESET)
		(rx_hit && !rx_hit_q) |=> raw_q[`UIRQ_BIT_RX])
		else $error("rx level event lost");

	// Transmit crossing of threshold raises its raw bit
	a_tx_level: assert property (@(posedge SYS_CLK) disable iff (RESET)
		(tx_hit && !tx_hit_q) |=> raw_q[`UIRQ_BIT_TX])
		else $error("tx level event lost");

	// Level write lands in both fields on the next edge
	a_level_write: assert property (@(posedge SYS_CLK) disable iff (RESET)
		(WR_STB && ADDR == `UIRQ_OFS_LEVEL)
		|=> {rx_trigger_level_q, tx_trigger_level_q} == $past(WDATA[5:0]))
		else $error("level write not stored");

	// Level read shows both fields, upper bits zero
	a_level_read: assert property (@(posedge SYS_CLK) disable iff (RESET)
		(RD_STB && ADDR == `UIRQ_OFS_LEVEL)
		|=> RDATA == {26'h0, $past(rx_trigger_level_q), $past(tx_trigger_level_q)})
		else $error("level readback wrong");

	// Raw read returns the pending bits of the read cycle
	a_raw_read: assert property (@(posedge SYS_CLK) disable iff (RESET)
		(RD_STB && ADDR == `UIRQ_OFS_RAW) |=> RDATA == {19'h0, $past(raw_q)})
		else $error("raw readback wrong");

	// Unused source positions never pend
	a_raw_reserved: assert property (@(posedge SYS_CLK) disable iff (RESET)
		raw_q[0] == 1'b0 && raw_q[3:2] == 2'h0)
		else $error("reserved raw bit set");

	// Unused mask positions never hold a one
	a_mask_reserved: assert property (@(posedge SYS_CLK) disable iff (RESET)
		mask_q[0] == 1'b0 && mask_q[3:2] == 2'h0)
		else $error("reserved mask bit set");

	// Clear register is write-only, so reading it gives zero
	a_clear_reads_zero: assert property (@(posedge SYS_CLK) disable iff (RESET)
		(RD_STB && ADDR == `UIRQ_OFS_CLEAR) |=> RDATA == 32'h0)
		else $error("clear register read not zero");

	// Writing the raw register changes nothing when no source fires
	a_raw_read_only: assert property (@(posedge SYS_CLK) disable iff (RESET)
		(WR_STB && ADDR == `UIRQ_OFS_RAW && set_v == '0) |=> raw_q == $past(raw_q))
		else $error("raw register took a write");

	// An enabled event raises the line one edge later, no extra latency
	a_irq_on_event: assert property (@(posedge SYS_CLK) disable iff (RESET)
		(OVERRUN_ERR_EV && mask_q[`UIRQ_BIT_OE] && !WR_STB) |=> IRQ)
		else $error("irq late after enabled event");

	// With every source disabled the line stays low
	a_irq_masked_off: assert property (@(posedge SYS_CLK) disable iff (RESET)
		(mask_q == '0) |-> !IRQ)
		else $error("irq high with all sources disabled");

	// Clear-to-send change pends its bit
	a_cts_sets: assert property (@(posedge SYS_CLK) disable iff (RESET)
		CTS_CHANGE_EV |=> raw_q[`UIRQ_BIT_CTS])
		else $error("cts change event lost");

	// Receive timeout pends its bit
	a_timeout_sets: assert property (@(posedge SYS_CLK) disable iff (RESET)
		RX_TIMEOUT_EV |=> raw_q[`UIRQ_BIT_RXTO])
		else $error("rx timeout event lost");

	// Break error pends its bit
	a_break_sets: assert property (@(posedge SYS_CLK) disable iff (RESET)
		BREAK_ERR_EV |=> raw_q[`UIRQ_BIT_BE])
		else $error("break event lost");

	// Flow stop pends its bit
	a_flow_stop_sets: assert property (@(posedge SYS_CLK) disable iff (RESET)
		FLOW_STOP_EV |=> raw_q[`UIRQ_BIT_XOFF])
		else $error("flow stop event lost");

	// Transmit FIFO empty pends its bit
	a_tx_empty_sets: assert property (@(posedge SYS_CLK) disable iff (RESET)
		TX_EMPTY_EV |=> raw_q[`UIRQ_BIT_TXFE])
		else $error("tx empty event lost");

	// A pending bit stays until software clears it
	a_pending_sticky: assert property (@(posedge SYS_CLK) disable iff (RESET)
		(raw_q[`UIRQ_BIT_FE] && !(WR_STB && ADDR == `UIRQ_OFS_CLEAR))
		|=> raw_q[`UIRQ_BIT_FE])
		else $error("framing bit dropped without clear");

	// No parity event, no parity pending
	a_parity_quiet: assert property (@(posedge SYS_CLK) disable iff (RESET)
		(!raw_q[`UIRQ_BIT_PE] && !PARITY_ERR_EV) |=> !raw_q[`UIRQ_BIT_PE])
		else $error("parity bit set with no event");

	// Code 010b: transmit level met at one eighth of the FIFO free
	a_tx_eighth: assert property (@(posedge SYS_CLK) disable iff (RESET)
		(tx_trigger_level_q == 3'h2) |-> tx_hit == (TX_FIFO_FREE >= CW'(DEPTH / 8)))
		else $error("tx one eighth threshold wrong");

	// Code 011b: transmit level met at one quarter free
	a_tx_quarter: assert property (@(posedge SYS_CLK) disable iff (RESET)
		(tx_trigger_level_q == 3'h3) |-> tx_hit == (TX_FIFO_FREE >= CW'(DEPTH / 4)))
		else $error("tx one quarter threshold wrong");

	// Code 110b: receive level met at three quarters full
	a_rx_three_quarter: assert property (@(posedge SYS_CLK) disable iff (RESET)
		(rx_trigger_level_q == 3'h6) |-> rx_hit == (RX_FIFO_FILL >= CW'((DEPTH * 3) / 4)))
		else $error("rx three quarter threshold wrong");
endmodule
`default_nettype wire

// ==== dv/uirq_top_tb.sv ====
// Self-checking bench for the UART interrupt slice: registers, events, levels
`timescale 1ns/1ps
`default_nettype none
`include "uirq_consts.svh"
module uirq_top_tb;
	logic sys_clk, reset, wr_stb, rd_stb, irq;
	logic [7:0] addr;
	logic [7:0] ev;
	logic [31:0] wdata, rdata;
	logic [6:0] tx_free, rx_fill;
	int mismatches, num_checks;
	int bits [8] = '{1, 6, 7, 8, 9, 10, 11, 12};
	int th [8] = '{1, 4, 8, 16, 32, 48, 48, 48};

	uirq_top dut (.SYS_CLK(sys_clk), .RESET(reset), .ADDR(addr), .WDATA(wdata),
		.WR_STB(wr_stb), .RD_STB(rd_stb), .RDATA(rdata), .TX_FIFO_FREE(tx_free),
		.RX_FIFO_FILL(rx_fill), .CTS_CHANGE_EV(ev[0]), .RX_TIMEOUT_EV(ev[1]),
		.FRAMING_ERR_EV(ev[2]), .PARITY_ERR_EV(ev[3]), .BREAK_ERR_EV(ev[4]),
		.OVERRUN_ERR_EV(ev[5]), .FLOW_STOP_EV(ev[6]), .TX_EMPTY_EV(ev[7]), .IRQ(irq));

	// 50 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Write returns 1 ns after its edge so IRQ can be sampled settled
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge sys_clk);
		wr_stb <= 1'b0;
		#1;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		@(posedge sys_clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge sys_clk);
		rd_stb <= 1'b0;
		#1;
		chk(what, exp, rdata);
	endtask

	task automatic give_verdict();
		if (mismatches == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Hang guard, counted as a mismatch
	initial begin
		#1000000;
		mismatches++;
		give_verdict();
	end

	initial begin
		reset = 1'b1;
		addr = 8'h00;
		wdata = 32'h00000000;
		wr_stb = 1'b0;
		rd_stb = 1'b0;
		tx_free = 7'h00;
		rx_fill = 7'h00;
		ev = 8'h00;
		repeat (10) @(posedge sys_clk);
		reset <= 1'b0;
		// Reset values, then reserved, read-only and unmapped places
		rdchk("level", `UIRQ_OFS_LEVEL, 32'h00000012);
		rdchk("mask", `UIRQ_OFS_MASK, 32'h00000000);
		rdchk("raw", `UIRQ_OFS_RAW, 32'h00000000);
		chk("irq", 32'h00000000, {31'h0, irq});
		wr(`UIRQ_OFS_LEVEL, 32'hFFFFFFFF);
		rdchk("level", `UIRQ_OFS_LEVEL, 32'h0000003F);
		wr(`UIRQ_OFS_MASK, 32'hFFFFFFFF);
		rdchk("mask", `UIRQ_OFS_MASK, 32'h00001FF2);
		wr(`UIRQ_OFS_RAW, 32'hFFFFFFFF);
		rdchk("raw", `UIRQ_OFS_RAW, 32'h00000000);
		rdchk("clear reg", `UIRQ_OFS_CLEAR, 32'h00000000);
		rdchk("unmapped", 8'h48, 32'h00000000);
		wr(`UIRQ_OFS_MASK, 32'h00000000);
		// Each event source: pend, mask in, zero-clear ignored, one-clear drops it
		foreach (bits[i]) begin
			@(posedge sys_clk);
			ev <= 8'h01 << i;
			@(posedge sys_clk);
			ev <= 8'h00;
			#1;
			chk("irq masked", 32'h00000000, {31'h0, irq});
			rdchk("raw", `UIRQ_OFS_RAW, 32'h1 << bits[i]);
			rdchk("masked", `UIRQ_OFS_MASKED, 32'h00000000);
			wr(`UIRQ_OFS_MASK, 32'h1 << bits[i]);
			chk("irq", 32'h00000001, {31'h0, irq});
			rdchk("masked", `UIRQ_OFS_MASKED, 32'h1 << bits[i]);
			wr(`UIRQ_OFS_CLEAR, ~(32'h1 << bits[i]));
			rdchk("raw kept", `UIRQ_OFS_RAW, 32'h1 << bits[i]);
			wr(`UIRQ_OFS_CLEAR, 32'h1 << bits[i]);
			chk("irq", 32'h00000000, {31'h0, irq});
			rdchk("raw", `UIRQ_OFS_RAW, 32'h00000000);
			wr(`UIRQ_OFS_MASK, 32'h00000000);
		end
		// Enabled event raises IRQ at once; an event in its own clear cycle wins
		wr(`UIRQ_OFS_MASK, 32'h00000400);
		@(posedge sys_clk);
		ev <= 8'h20;
		@(posedge sys_clk);
		ev <= 8'h00;
		#1;
		chk("irq at event", 32'h00000001, {31'h0, irq});
		@(posedge sys_clk);
		addr <= `UIRQ_OFS_CLEAR;
		wdata <= 32'h00000400;
		wr_stb <= 1'b1;
		ev <= 8'h20;
		@(posedge sys_clk);
		wr_stb <= 1'b0;
		ev <= 8'h00;
		#1;
		chk("irq kept", 32'h00000001, {31'h0, irq});
		rdchk("set wins", `UIRQ_OFS_RAW, 32'h00000400);
		wr(`UIRQ_OFS_CLEAR, 32'h00000400);
		chk("irq cleared", 32'h00000000, {31'h0, irq});
		wr(`UIRQ_OFS_MASK, 32'h00000000);
		// Every trigger code: one below the threshold stays quiet, reaching it pends
		for (int c = 0; c < 8; c++) begin
			wr(`UIRQ_OFS_LEVEL, {26'h0, 3'(c), 3'(c)});
			wr(`UIRQ_OFS_CLEAR, 32'h00000030);
			@(posedge sys_clk);
			tx_free <= 7'(th[c] - 1);
			rx_fill <= 7'(th[c] - 1);
			rdchk("below", `UIRQ_OFS_RAW, 32'h00000000);
			@(posedge sys_clk);
			tx_free <= 7'(th[c]);
			rx_fill <= 7'(th[c]);
			rdchk("at level", `UIRQ_OFS_RAW, 32'h00000030);
		end
		// Reset in mid-run restores mask, levels, pending bits and the line
		wr(`UIRQ_OFS_MASK, 32'h00001FF2);
		chk("irq before reset", 32'h00000001, {31'h0, irq});
		@(posedge sys_clk);
		reset <= 1'b1;
		tx_free <= 7'h00;
		rx_fill <= 7'h00;
		repeat (2) @(posedge sys_clk);
		reset <= 1'b0;
		rdchk("mask", `UIRQ_OFS_MASK, 32'h00000000);
		rdchk("level", `UIRQ_OFS_LEVEL, 32'h00000012);
		rdchk("raw", `UIRQ_OFS_RAW, 32'h00000000);
		chk("irq", 32'h00000000, {31'h0, irq});
		give_verdict();
	end
endmodule
`default_nettype wire
